// ==== include/strap_pkg.sv ====
package strap_pkg;

    // index/data i/o port pair
    localparam logic [15:0] INDEX_PORT_ADDR = 16'h0022;
    localparam logic [15:0] DATA_PORT_ADDR = 16'h0023;

    // register indices behind the data port
    localparam logic [7:0] IDX_CAPTURE_ONE = 8'h4B;
    localparam logic [7:0] IDX_CAPTURE_TWO = 8'h4C;
    localparam logic [7:0] IDX_HOST_CLOCK = 8'h5F;

    // field positions
    localparam int CAP1_RSV_LSB = 2;
    localparam int CAP1_RSV_MSB = 5;
    localparam int CAP2_CORE_MULT_BIT = 7;
    localparam int CAP2_DOT_SRC_BIT = 4;
    localparam int CAP2_PCI_DIV_BIT = 1;
    localparam int HOST_CODE_LSB = 3;
    localparam int HOST_CODE_MSB = 7;

    // reserved bits read as this value
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;

    // host clock synthesizer codes, pin 3 strap in the msb
    localparam logic [4:0] HCODE_25 = 5'h00;
    localparam logic [4:0] HCODE_50 = 5'h01;
    localparam logic [4:0] HCODE_60 = 5'h02;
    localparam logic [4:0] HCODE_66 = 5'h03;
    localparam logic [4:0] HCODE_75 = 5'h09;
    localparam logic [4:0] HCODE_90 = 5'h13;
    localparam logic [4:0] HCODE_100 = 5'h19;

    // host clock frequencies in mhz
    localparam logic [7:0] MHZ_25 = 8'h19;
    localparam logic [7:0] MHZ_50 = 8'h32;
    localparam logic [7:0] MHZ_60 = 8'h3C;
    localparam logic [7:0] MHZ_66 = 8'h42;
    localparam logic [7:0] MHZ_75 = 8'h4B;
    localparam logic [7:0] MHZ_90 = 8'h5A;
    localparam logic [7:0] MHZ_100 = 8'h64;

    // strap pins as they arrive from the memory data bus
    typedef struct packed {
        logic [3:0] reserved_strap_pins;
        logic core_multiplier_strap;
        logic dot_clock_source_strap;
        logic pci_divisor_strap;
        logic [1:0] host_freq_strap_high;
        logic [2:0] host_freq_strap_low;
    } strap_pins_type;

    localparam int STRAP_PIN_WIDTH = $bits(strap_pins_type);

    // one i/o cycle on the index/data port
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_type;

    typedef enum logic {
        PHASE_CAPTURE,
        PHASE_RUN
    } strap_phase_type;

endpackage

// ==== hw/strap_sync.sv ====
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 12
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // refused at elaboration; a zero-wide bundle has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("strap_sync: WIDTH must be at least 1");
    end

    // two flops per pin; no reset on purpose, so the pins are
    // already settled when the capture registers sample during reset
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic stable_reg;
            always_ff @(posedge clk_i) begin
                meta_reg <= async_i[i];
                stable_reg <= meta_reg;
            end
            assign sync_o[i] = stable_reg;
        end
    endgenerate

endmodule

// ==== hw/power_on_strap_registers.sv ====
// How it works
// - capture one index 0x4B bits 5..2 hold reserved pins sampled at reset
// - capture two bit 7 holds core multiplier strap and sets core clock
// - dot clock source bit 0: dot clock pin is an input, clock external
// - dot clock source bit 1: pin driven from internal synthesizer output
// - software may write and read the dot clock source bit
// - bit 1 of capture two mirrors pci divisor strap on one variant only
// - host clock index 0x5F bits 7..3 hold pins 3,2,26,25,24; programs synthesizer
// - host codes map to 25,50,60,66,75,90,100 mhz
// - index written at port 0x22, data moved through port 0x23
// - reset values of the registers are the captured strap levels
// - core multiplier strap low selects x1, high selects x2
`timescale 1ns/1ps
module power_on_strap_registers
    import strap_pkg::*;
#(
    parameter bit HAS_CORE_MULT = 1'b1,
    parameter bit HAS_PCI_DIVISOR = 1'b0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    // strap pins on the memory data bus
    input wire logic [3:0] reserved_strap_pins_i,
    input wire logic core_multiplier_strap_i,
    input wire logic dot_clock_source_strap_i,
    input wire logic pci_divisor_strap_i,
    input wire logic [1:0] host_freq_strap_high_i,
    input wire logic [2:0] host_freq_strap_low_i,
    // index/data i/o port
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rack_o,
    // dot clock pin and its internal source
    input wire logic synth_dot_clock_i,
    input wire logic dot_clock_i,
    output logic dot_clock_o,
    output logic dot_clock_oe_o,
    output logic dot_clock_ext_o,
    // configuration results
    output logic core_mult_x2_o,
    output logic pci_divisor_o,
    output logic [4:0] host_freq_code_o,
    output logic [7:0] host_freq_mhz_o,
    output logic host_freq_valid_o,
    output logic straps_valid_o
);

    // pin synchronisation: straps are board levels with no relation to
    // the core clock, so every pin crosses two flops before use
    strap_pins_type pins_raw;
    strap_pins_type pins_sync;
    logic [STRAP_PIN_WIDTH-1:0] pins_sync_bits;

    // field layout must match the pin bundle, or the images misalign
    localparam int HOST_CODE_WIDTH = HOST_CODE_MSB - HOST_CODE_LSB + 1;
    localparam int RSV_FIELD_WIDTH = CAP1_RSV_MSB - CAP1_RSV_LSB + 1;

    if (HOST_CODE_WIDTH != $bits(pins_raw.host_freq_strap_high)
            + $bits(pins_raw.host_freq_strap_low)) begin : g_bad_host_field
        $error("power_on_strap_registers: host code field width mismatch");
    end
    if (RSV_FIELD_WIDTH != $bits(pins_raw.reserved_strap_pins)) begin : g_bad_rsv_field
        $error("power_on_strap_registers: reserved field width mismatch");
    end

    // gather the pins so they cross in one bundle
    assign pins_raw.reserved_strap_pins = reserved_strap_pins_i;
    assign pins_raw.core_multiplier_strap = core_multiplier_strap_i;
    assign pins_raw.dot_clock_source_strap = dot_clock_source_strap_i;
    assign pins_raw.pci_divisor_strap = pci_divisor_strap_i;
    assign pins_raw.host_freq_strap_high = host_freq_strap_high_i;
    assign pins_raw.host_freq_strap_low = host_freq_strap_low_i;

    // one synchroniser instance serves the whole bundle
    strap_sync #(
        .WIDTH(STRAP_PIN_WIDTH)
    ) u_strap_sync (
        .clk_i(clk_i),
        .async_i(pins_raw),
        .sync_o(pins_sync_bits)
    );

    // the flops carry bare bits; restore the field view here
    assign pins_sync = strap_pins_type'(pins_sync_bits);

    // capture phase: one state flop tells the pin driver and straps_valid_o
    // that the captures have been frozen

    strap_phase_type phase_reg;
    strap_phase_type phase_next;

    // capture phase holds through reset and one cycle past release, then run for good
    always_comb begin
        case (phase_reg)
            PHASE_CAPTURE: phase_next = PHASE_RUN;
            PHASE_RUN: phase_next = PHASE_RUN;
            default: phase_next = PHASE_CAPTURE;
        endcase
    end

    // only reset forces capture; nothing else can reopen it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            phase_reg <= PHASE_CAPTURE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // high from the second cycle after release until the next reset
    assign straps_valid_o = (phase_reg == PHASE_RUN);

    // captured strap state; all but dot_src_reg have no run-time write path,
    // which is what keeps them stable until the next reset

    logic [3:0] cap_reserved_reg;
    logic cap_core_mult_reg;
    logic cap_pci_div_reg;
    logic [4:0] cap_host_code_reg;
    logic dot_src_reg;
    logic dot_src_next;

    // sampled every cycle of reset; the last sample before release
    // sticks, so reset must outlast the two synchroniser flops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cap_reserved_reg <= pins_sync.reserved_strap_pins;
            cap_core_mult_reg <= pins_sync.core_multiplier_strap;
            cap_pci_div_reg <= pins_sync.pci_divisor_strap;
            cap_host_code_reg <= {pins_sync.host_freq_strap_high,
                                  pins_sync.host_freq_strap_low};
        end
    end

    // index/data port decode: two addresses reach every register, the
    // stored index picks which one the data port talks to

    io_req_type io_req;
    logic [7:0] index_reg;
    logic [7:0] index_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rack_reg;

    // bus inputs share the core clock, so no synchroniser here
    assign io_req.addr = io_addr_i;
    assign io_req.wr = io_wr_i;
    assign io_req.rd = io_rd_i;
    assign io_req.wdata = io_wdata_i;

    // port hits, then which register the stored index names
    wire hit_index = (io_req.addr == INDEX_PORT_ADDR);
    wire hit_data = (io_req.addr == DATA_PORT_ADDR);
    wire sel_one = (index_reg == IDX_CAPTURE_ONE);
    wire sel_two = (index_reg == IDX_CAPTURE_TWO);
    wire sel_host = (index_reg == IDX_HOST_CLOCK);
    // qualified strobes; other addresses belong to other devices
    wire index_wr = hit_index && io_req.wr;
    wire data_wr = hit_data && io_req.wr;
    wire port_rd = (hit_index || hit_data) && io_req.rd;

    // index port remembers the last index written
    assign index_next = index_wr ? io_req.wdata : index_reg;

    // index resets to zero, which names no register and reads 0
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            index_reg <= INDEX_RESET;
        end else begin
            index_reg <= index_next;
        end
    end

    // only the dot clock source bit takes data; every other bit of
    // every register ignores the write and keeps its capture
    assign dot_src_next = (data_wr && sel_two) ?
        io_req.wdata[CAP2_DOT_SRC_BIT] : dot_src_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dot_src_reg <= pins_sync.dot_clock_source_strap;
        end else begin
            dot_src_next_hold: dot_src_reg <= dot_src_next;
        end
    end

    // register images: reserved bits read as zero, and the variant
    // parameters decide which optional bits are populated

    logic [7:0] img_one;
    logic [7:0] img_two;
    logic [7:0] img_host;

    // capture one: only the reserved pin field is populated
    always_comb begin
        img_one = REG_ZERO;
        img_one[CAP1_RSV_MSB:CAP1_RSV_LSB] = cap_reserved_reg;
    end

    // capture two: multiplier and pci bits depend on the variant
    always_comb begin
        img_two = REG_ZERO;
        img_two[CAP2_CORE_MULT_BIT] = HAS_CORE_MULT & cap_core_mult_reg;
        img_two[CAP2_DOT_SRC_BIT] = dot_src_reg;
        img_two[CAP2_PCI_DIV_BIT] = HAS_PCI_DIVISOR & cap_pci_div_reg;
    end

    // host clock: code in 7..3, low bits reserved
    always_comb begin
        img_host = REG_ZERO;
        img_host[HOST_CODE_MSB:HOST_CODE_LSB] = cap_host_code_reg;
    end

    // the index port reads back too, so software can save it
    // read mux; an unknown index reads zero rather than bus junk
    always_comb begin
        rdata_next = REG_ZERO;
        if (hit_index) begin
            rdata_next = index_reg;
        end else if (sel_one) begin
            rdata_next = img_one;
        end else if (sel_two) begin
            rdata_next = img_two;
        end else if (sel_host) begin
            rdata_next = img_host;
        end
    end

    // read data lands one cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg <= REG_ZERO;
            rack_reg <= 1'b0;
        end else begin
            rack_reg <= port_rd;
            if (port_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign io_rdata_o = rdata_reg;
    assign io_rack_o = rack_reg;

    // dot clock pin direction: the source bit, captured or written,
    // decides who owns the pin

    // the pin is only driven once capture is over, so a board that
    // strapped it as an input never sees contention during reset
    assign dot_clock_oe_o = dot_src_reg && straps_valid_o;
    // synthesizer clock passes straight through; a flop would halve it
    assign dot_clock_o = dot_src_reg ? synth_dot_clock_i : 1'b0;
    // the inbound path is gated so a driven pin never loops back
    assign dot_clock_ext_o = dot_src_reg ? 1'b0 : dot_clock_i;

    // core multiplier and pci divisor; an absent feature reads 0
    // whatever the board strapped, so software sees a fixed value

    assign core_mult_x2_o = HAS_CORE_MULT & cap_core_mult_reg;
    assign pci_divisor_o = HAS_PCI_DIVISOR & cap_pci_div_reg;

    // host clock synthesizer programming from the frozen code
    // pin 3 strap is the msb of the code, pin 24 strap the lsb
    logic [7:0] host_mhz;
    logic host_known;
    logic [7:0] host_mhz_reg;
    logic host_known_reg;

    // codes outside the table leave the frequency unknown
    // unlisted codes are still captured and visible in the register
    always_comb begin
        host_known = 1'b1;
        case (cap_host_code_reg)
            HCODE_25: host_mhz = MHZ_25;
            HCODE_50: host_mhz = MHZ_50;
            HCODE_60: host_mhz = MHZ_60;
            HCODE_66: host_mhz = MHZ_66;
            HCODE_75: host_mhz = MHZ_75;
            HCODE_90: host_mhz = MHZ_90;
            HCODE_100: host_mhz = MHZ_100;
            default: begin
                host_mhz = REG_ZERO;
                host_known = 1'b0;
            end
        endcase
    end

    // decode registered so the frequency output comes from a flop;
    // the code is frozen at release, so the extra cycle is unseen
    always_ff @(posedge clk_i) begin
        host_mhz_reg <= host_mhz;
        host_known_reg <= host_known;
    end

    assign host_freq_code_o = cap_host_code_reg;
    assign host_freq_mhz_o = host_mhz_reg;
    assign host_freq_valid_o = host_known_reg && straps_valid_o;

endmodule

// ==== testbench/strap_board.sv ====
`timescale 1ns/1ps
module strap_board
    import strap_pkg::*;
(
    input wire strap_pins_type pattern_i,
    output strap_pins_type pins_o,
    output logic osc_o
);
    // resistors hold their level all the time, there is no released state
    assign pins_o = pattern_i;
    // external dot clock oscillator, free running, unrelated to the core clock
    initial begin
        osc_o = 1'b0;
        forever #130 osc_o = ~osc_o;
    end
endmodule

// ==== testbench/power_on_strap_registers_sva.sv ====
`timescale 1ns/1ps
module strap_registers_sva
    import strap_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rack_o,
    input wire logic synth_dot_clock_i,
    input wire logic dot_clock_i,
    input wire logic dot_clock_o,
    input wire logic dot_clock_oe_o,
    input wire logic dot_clock_ext_o,
    input wire logic core_mult_x2_o,
    input wire logic [4:0] host_freq_code_o,
    input wire logic straps_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // port decode, mirrored so the checker does not trust the design's index
    logic [7:0] idx_reg;
    wire port_hit = io_addr_i == INDEX_PORT_ADDR || io_addr_i == DATA_PORT_ADDR;
    wire data_hit = io_addr_i == DATA_PORT_ADDR;
    wire src_bit = io_wdata_i[CAP2_DOT_SRC_BIT];
    // index copy follows writes to the index port only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            idx_reg <= INDEX_RESET;
        end else if (io_wr_i && io_addr_i == INDEX_PORT_ADDR) begin
            idx_reg <= io_wdata_i;
        end
    end
    a_rack_after_read: assert property (io_rd_i && port_hit |=> io_rack_o)
        else $error("port read got no answer");
    a_rack_needs_read: assert property (io_rack_o |-> $past(io_rd_i && port_hit))
        else $error("answer without a port read");
    a_pin_from_synth: assert property (dot_clock_oe_o |-> dot_clock_o == synth_dot_clock_i && !dot_clock_ext_o)
        else $error("driven pin not fed by synthesizer");
    a_pin_as_input: assert property (straps_valid_o && !dot_clock_oe_o |-> dot_clock_ext_o == dot_clock_i)
        else $error("external dot clock not forwarded");
    a_source_write: assert property (io_wr_i && data_hit && idx_reg == IDX_CAPTURE_TWO |=> dot_clock_oe_o == $past(src_bit))
        else $error("source bit write not applied");
    a_host_image: assert property (io_rack_o && $past(data_hit) && idx_reg == IDX_HOST_CLOCK |-> io_rdata_o == {host_freq_code_o, 3'b000})
        else $error("host clock register image wrong");
    a_straps_stable: assert property (straps_valid_o && $past(straps_valid_o) |-> $stable(host_freq_code_o) && $stable(core_mult_x2_o))
        else $error("captured strap changed after release");
    a_valid_release: assert property ($fell(srst_i) |-> !straps_valid_o ##1 straps_valid_o)
        else $error("straps valid timing wrong");
    c_host_read: cover property (io_rack_o && idx_reg == IDX_HOST_CLOCK);
    c_pin_out: cover property (dot_clock_oe_o);
    c_source_write: cover property (io_wr_i && data_hit && idx_reg == IDX_CAPTURE_TWO);
endmodule
bind power_on_strap_registers strap_registers_sva chk_u (.clk_i, .srst_i, .io_addr_i,
    .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rack_o, .synth_dot_clock_i,
    .dot_clock_i, .dot_clock_o, .dot_clock_oe_o, .dot_clock_ext_o, .core_mult_x2_o,
    .host_freq_code_o, .straps_valid_o);

// ==== testbench/power_on_strap_registers_tb.sv ====
`timescale 1ns/1ps
module power_on_strap_registers_tb;
    import strap_pkg::*;
    localparam bit MULT = 1'b1;
    localparam bit PCI = 1'b0;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [7:0] io_wdata_i = 8'h00;
    logic synth_dot_clock_i = 1'b0;
    strap_pins_type pat = '0;
    strap_pins_type pins;
    logic osc, dot_pin, io_rack_o, dot_clock_o, dot_clock_oe_o, dot_clock_ext_o;
    logic core_mult_x2_o, pci_divisor_o, host_freq_valid_o, straps_valid_o;
    logic [7:0] io_rdata_o, host_freq_mhz_o;
    logic [4:0] host_freq_code_o;
    logic alt_mult, alt_pci;
    int failures = 0;
    int n_tests = 0;
    strap_board board_u (.pattern_i(pat), .pins_o(pins), .osc_o(osc));
    // the device wins the pin while it drives, else the board oscillator shows
    assign dot_pin = dot_clock_oe_o ? dot_clock_o : osc;
    power_on_strap_registers #(.HAS_CORE_MULT(MULT), .HAS_PCI_DIVISOR(PCI)) dut_u (
        .clk_i, .srst_i, .reserved_strap_pins_i(pins.reserved_strap_pins),
        .core_multiplier_strap_i(pins.core_multiplier_strap),
        .dot_clock_source_strap_i(pins.dot_clock_source_strap),
        .pci_divisor_strap_i(pins.pci_divisor_strap),
        .host_freq_strap_high_i(pins.host_freq_strap_high),
        .host_freq_strap_low_i(pins.host_freq_strap_low), .io_addr_i, .io_wr_i, .io_rd_i,
        .io_wdata_i, .io_rdata_o, .io_rack_o, .synth_dot_clock_i, .dot_clock_i(dot_pin),
        .dot_clock_o, .dot_clock_oe_o, .dot_clock_ext_o, .core_mult_x2_o, .pci_divisor_o,
        .host_freq_code_o, .host_freq_mhz_o, .host_freq_valid_o, .straps_valid_o);
    // second variant: multiplier absent, pci divisor present
    power_on_strap_registers #(.HAS_CORE_MULT(1'b0), .HAS_PCI_DIVISOR(1'b1)) alt_u (
        .clk_i, .srst_i, .reserved_strap_pins_i(pins.reserved_strap_pins),
        .core_multiplier_strap_i(pins.core_multiplier_strap),
        .dot_clock_source_strap_i(pins.dot_clock_source_strap),
        .pci_divisor_strap_i(pins.pci_divisor_strap),
        .host_freq_strap_high_i(pins.host_freq_strap_high),
        .host_freq_strap_low_i(pins.host_freq_strap_low), .io_addr_i, .io_wr_i, .io_rd_i,
        .io_wdata_i, .io_rdata_o(), .io_rack_o(), .synth_dot_clock_i, .dot_clock_i(dot_pin),
        .dot_clock_o(), .dot_clock_oe_o(), .dot_clock_ext_o(), .core_mult_x2_o(alt_mult),
        .pci_divisor_o(alt_pci), .host_freq_code_o(), .host_freq_mhz_o(),
        .host_freq_valid_o(), .straps_valid_o());
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        synth_dot_clock_i <= ~synth_dot_clock_i;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
    endtask
    // read strobe is one cycle; the answer is looked for over a few cycles
    task automatic get(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge clk_i);
        io_rd_i <= 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (io_rack_o === 1'b1) begin
                ok = 1'b1;
                d = io_rdata_o;
            end else begin
                @(posedge clk_i);
            end
        end
    endtask
    task automatic rreg(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic ok;
        put(INDEX_PORT_ADDR, idx);
        get(DATA_PORT_ADDR, d, ok);
        chk({what, " answer"}, 8'h01, {7'b0, ok});
        chk(what, exp, d);
    endtask
    task automatic start(input strap_pins_type p);
        @(posedge clk_i);
        srst_i <= 1'b1;
        pat <= p;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("straps valid", 8'h01, {7'b0, straps_valid_o});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk_i);
        failures++;
        conclude();
    end
    // one reset per host code, with the other straps varied alongside
    initial begin
        static logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h13, 5'h19, 5'h1F};
        static logic [7:0] mhz [8] = '{8'h19, 8'h32, 8'h3C, 8'h42, 8'h4B, 8'h5A, 8'h64, 8'h00};
        logic [7:0] d, c2, hc;
        logic ok;
        for (int k = 0; k < 8; k++) begin
            start({4'(k + 5), k[0], k[1], ~k[0], codes[k]});
            hc = {codes[k], 3'b000};
            c2 = {k[0] & MULT, 2'b00, k[1], 2'b00, ~k[0] & PCI, 1'b0};
            chk("mhz", mhz[k], host_freq_mhz_o);
            chk("code valid", {7'b0, k < 7}, {7'b0, host_freq_valid_o});
            chk("code", {3'b000, codes[k]}, {3'b000, host_freq_code_o});
            chk("multiplier", {7'b0, k[0] & MULT}, {7'b0, core_mult_x2_o});
            chk("pci divisor", {7'b0, ~k[0] & PCI}, {7'b0, pci_divisor_o});
            chk("alt pci divisor", {7'b0, ~k[0]}, {7'b0, alt_pci});
            chk("alt multiplier", 8'h00, {7'b0, alt_mult});
            chk("pin enable", {7'b0, k[1]}, {7'b0, dot_clock_oe_o});
            rreg(IDX_HOST_CLOCK, hc, "host reg");
            rreg(IDX_CAPTURE_TWO, c2, "strap two");
            rreg(IDX_CAPTURE_ONE, {2'b00, 4'(k + 5), 2'b00}, "strap one");
            @(posedge clk_i);
            pat <= ~pat;
            rreg(IDX_HOST_CLOCK, hc, "host held");
            put(INDEX_PORT_ADDR, IDX_CAPTURE_TWO);
            put(DATA_PORT_ADDR, ~c2);
            rreg(IDX_CAPTURE_TWO, c2 ^ 8'h10, "strap two written");
            chk("pin enable written", {7'b0, ~k[1]}, {7'b0, dot_clock_oe_o});
            put(INDEX_PORT_ADDR, IDX_HOST_CLOCK);
            put(DATA_PORT_ADDR, 8'hFF);
            rreg(IDX_HOST_CLOCK, hc, "host write ignored");
            get(INDEX_PORT_ADDR, d, ok);
            chk("index port", IDX_HOST_CLOCK, d);
            rreg(8'h10, 8'h00, "unmapped");
            get(16'h0024, d, ok);
            chk("stray read answer", 8'h00, {7'b0, ok});
            $display("test %0d done", k);
        end
        conclude();
    end
endmodule
